// ==== rtl/sysref_cfg_pkg.sv ====
package sysref_cfg_pkg;

    // output counts of the register map
    localparam int REF_LANES = 8;
    localparam int REF_REGS  = 7;
    localparam int CLK_OUTS  = 8;

    // register offsets, index 0 = first listed output
    localparam logic [6:0][7:0] REF_DLY_ADDR = {8'h58, 8'h49, 8'h39, 8'h38, 8'h2a, 8'h29, 8'h28};
    localparam logic [6:0][7:0] REF_ST_ADDR  = {8'h5c, 8'h4c, 8'h3d, 8'h3c, 8'h2e, 8'h2d, 8'h2c};
    localparam logic [7:0][7:0] CLK_ST_ADDR  = {8'h65, 8'h64, 8'h54, 8'h45, 8'h35, 8'h34, 8'h25, 8'h24};
    localparam logic [7:0]      CLK_EN0_ADDR = 8'h74;
    localparam logic [7:0]      CLK_EN1_ADDR = 8'h75;
    localparam logic [7:0]      REF_EN_ADDR  = 8'h76;

    // writable bits of each register kind
    localparam logic [7:0] REF_DLY_MASK = 8'h7f;
    localparam logic [7:0] REF_ST_MASK  = 8'hbc;
    localparam logic [7:0] CLK_ST_MASK  = 8'h9c;
    localparam logic [7:0] CLK_EN0_MASK = 8'hdb;
    localparam logic [7:0] CLK_EN1_MASK = 8'h03;
    localparam logic [7:0] REF_EN_MASK  = 8'hff;

    // values after reset
    localparam logic [7:0] REF_DLY_RST = 8'h10;
    localparam logic [7:0] REF_ST_RST  = 8'h00;
    localparam logic [7:0] CLK_ST_RST  = 8'h00;
    localparam logic [7:0] EN_RST      = 8'h00;

    // field positions
    localparam int FINE_LO_LSB = 5;
    localparam int SRC_BIT     = 4;
    localparam int COARSE_LSB  = 1;
    localparam int FINE_HI_BIT = 0;
    localparam int PD_BIT      = 7;
    localparam int BIAS_BIT    = 5;
    localparam int FMT_BIT     = 4;
    localparam int AMP_LSB     = 2;

    // reference lane -> register set (c0 and c1 share the c registers)
    localparam logic [7:0][2:0] REF_LANE_REG = {3'h6, 3'h5, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
    // clock output -> bit in {enable hi, enable lo}
    localparam logic [7:0][3:0] CLK_EN_POS   = {4'h9, 4'h8, 4'h0, 4'h1, 4'h3, 4'h4, 4'h6, 4'h7};

    // analog step sizes
    localparam int COARSE_STEP_PS = 255;
    localparam int AMP_STEP_MV    = 250;
    localparam logic [7:0][7:0] FINE_PS = {8'ha0, 8'h87, 8'h6e, 8'h55, 8'h4b, 8'h32, 8'h19, 8'h00};

    localparam int DLY_W = 11;
    localparam int AMP_W = 10;

    // decoded settings of one reference output
    typedef struct packed {
        logic             pd;
        logic             src_sysref;
        logic             bias;
        logic             lvpecl;
        logic             on;
        logic [AMP_W-1:0] amp_mv;
        logic [DLY_W-1:0] delay_ps;
    } ref_out_cfg_s;

    // decoded settings of one clock output
    typedef struct packed {
        logic             pd;
        logic             lvpecl;
        logic             on;
        logic [AMP_W-1:0] amp_mv;
    } clk_out_cfg_s;

    // whole state of the register bank
    typedef struct packed {
        logic [6:0][7:0]             ref_dly;
        logic [6:0][7:0]             ref_st;
        logic [7:0][7:0]             clk_st;
        logic [7:0]                  clk_en0;
        logic [7:0]                  clk_en1;
        logic [7:0]                  ref_en;
        logic [7:0]                  rdata;
        logic                        rvalid;
        ref_out_cfg_s [7:0]          ref_cfg;
        clk_out_cfg_s [7:0]          clk_cfg;
    } bank_state_s;

    // state of one output lane
    typedef struct packed {
        logic s1;
        logic s2;
        logic q;
    } lane_state_s;

endpackage

// ==== rtl/out_lane_gate.sv ====
`timescale 1ns/10ps
// brings one source level into core_clk and gates it
module out_lane_gate #(
    parameter int SYNC_STAGES = 2
) (
    input  wire logic core_clk,
    input  wire logic rstn,
    input  wire logic src_in,
    input  wire logic on,
    output logic      gated_out
);

    initial begin
        if (SYNC_STAGES != 2) begin
            $error("out_lane_gate: only two sync stages supported");
        end
    end

    sysref_cfg_pkg::lane_state_s st_reg;
    sysref_cfg_pkg::lane_state_s st_next;

    // two-flop sync, then low while off
    always_comb begin
        st_next    = st_reg;
        st_next.s1 = src_in;
        st_next.s2 = st_reg.s1;
        st_next.q  = on & st_reg.s2;
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign gated_out = st_reg.q;

endmodule // out_lane_gate

// ==== rtl/sysref_output_config_regs.sv ====
// Summary of operation
// - clock amplitude 00..11 gives 250..1000 mV
// - same amplitude levels in lvpecl format
// - format bit: 0 lvds, 1 lvpecl
// - enable 0 holds output low
// - source 0 takes channel divided clock
// - source 1, default, takes central sysref
// - fine code split d6:d5 and d0
// - state register: pd, bias (reference only), format, amplitude
// - register 0x76 holds eight reference enables
// - coarse delay is code times 255 ps
// - fine delay table 0 to 160 ps
// - power-down overrides format, enable, amplitude
// - bias bit selects lvds crossing bias
`timescale 1ns/10ps
module sysref_output_config_regs #(
    parameter int REF_LANES = 8,
    parameter int CLK_OUTS  = 8
) (
    input  wire logic                                  core_clk,
    input  wire logic                                  rstn,
    input  wire logic [7:0]                            reg_addr,
    input  wire logic [7:0]                            reg_wdata,
    input  wire logic                                  reg_wr,
    input  wire logic                                  reg_rd,
    output logic [7:0]                                 reg_rdata,
    output logic                                       reg_rvalid,
    input  wire logic                                  sysref_in,
    input  wire logic [REF_LANES-1:0]                  chan_div_clk,
    input  wire logic [CLK_OUTS-1:0]                   clk_src,
    output logic [REF_LANES-1:0]                       reference_output,
    output logic [CLK_OUTS-1:0]                        clock_output,
    output sysref_cfg_pkg::ref_out_cfg_s [7:0]         ref_cfg,
    output sysref_cfg_pkg::clk_out_cfg_s [7:0]         clk_cfg
);

    initial begin
        if (REF_LANES != sysref_cfg_pkg::REF_LANES || CLK_OUTS != sysref_cfg_pkg::CLK_OUTS) begin
            $error("sysref_output_config_regs: output counts are fixed by the register map");
        end
    end

    sysref_cfg_pkg::bank_state_s st_reg;
    sysref_cfg_pkg::bank_state_s st_next;

    logic [15:0]          clk_en_all;
    logic [REF_LANES-1:0] ref_src_pin;
    logic [REF_LANES-1:0] ref_on;
    logic [CLK_OUTS-1:0]  clk_on;

    assign clk_en_all = {st_reg.clk_en1, st_reg.clk_en0};

    // register writes, read mux and field decode
    always_comb begin
        logic [7:0] dly;
        logic [7:0] rst;
        logic [7:0] cst;
        logic [2:0] fine;
        logic [2:0] coarse;
        logic [1:0] amp;
        logic [2:0] ri;
        logic [7:0] rd;
        dly     = '0;
        rst     = '0;
        cst     = '0;
        fine    = '0;
        coarse  = '0;
        amp     = '0;
        ri      = '0;
        rd      = '0;
        st_next = st_reg;

        for (int i = 0; i < sysref_cfg_pkg::REF_REGS; i++) begin
            if (reg_wr && reg_addr == sysref_cfg_pkg::REF_DLY_ADDR[i]) begin
                st_next.ref_dly[i] = reg_wdata & sysref_cfg_pkg::REF_DLY_MASK;
            end
            if (reg_addr == sysref_cfg_pkg::REF_DLY_ADDR[i]) begin
                rd = st_reg.ref_dly[i];
            end
        end

        for (int i = 0; i < sysref_cfg_pkg::REF_REGS; i++) begin
            if (reg_wr && reg_addr == sysref_cfg_pkg::REF_ST_ADDR[i]) begin
                st_next.ref_st[i] = reg_wdata & sysref_cfg_pkg::REF_ST_MASK;
            end
            if (reg_addr == sysref_cfg_pkg::REF_ST_ADDR[i]) begin
                rd = st_reg.ref_st[i];
            end
        end

        for (int i = 0; i < CLK_OUTS; i++) begin
            if (reg_wr && reg_addr == sysref_cfg_pkg::CLK_ST_ADDR[i]) begin
                st_next.clk_st[i] = reg_wdata & sysref_cfg_pkg::CLK_ST_MASK;
            end
            if (reg_addr == sysref_cfg_pkg::CLK_ST_ADDR[i]) begin
                rd = st_reg.clk_st[i];
            end
        end

        if (reg_wr && reg_addr == sysref_cfg_pkg::CLK_EN0_ADDR) begin
            st_next.clk_en0 = reg_wdata & sysref_cfg_pkg::CLK_EN0_MASK;
        end
        if (reg_wr && reg_addr == sysref_cfg_pkg::CLK_EN1_ADDR) begin
            st_next.clk_en1 = reg_wdata & sysref_cfg_pkg::CLK_EN1_MASK;
        end
        if (reg_wr && reg_addr == sysref_cfg_pkg::REF_EN_ADDR) begin
            st_next.ref_en = reg_wdata & sysref_cfg_pkg::REF_EN_MASK;
        end
        if (reg_addr == sysref_cfg_pkg::CLK_EN0_ADDR) begin
            rd = st_reg.clk_en0;
        end
        if (reg_addr == sysref_cfg_pkg::CLK_EN1_ADDR) begin
            rd = st_reg.clk_en1;
        end
        if (reg_addr == sysref_cfg_pkg::REF_EN_ADDR) begin
            rd = st_reg.ref_en;
        end

        // read answer one cycle after the strobe, zero if unmapped
        st_next.rvalid = reg_rd;
        if (reg_rd) begin
            // stored masked, so reserved read zero
            st_next.rdata = rd;
        end

        // reference lane decode from current register values
        for (int k = 0; k < REF_LANES; k++) begin
            ri  = sysref_cfg_pkg::REF_LANE_REG[k];
            dly = st_reg.ref_dly[ri];
            rst = st_reg.ref_st[ri];
            // fine msb at d0, low bits at d6:d5
            fine   = {dly[sysref_cfg_pkg::FINE_HI_BIT], dly[sysref_cfg_pkg::FINE_LO_LSB +: 2]};
            coarse = dly[sysref_cfg_pkg::COARSE_LSB +: 3];
            amp    = rst[sysref_cfg_pkg::AMP_LSB +: 2];
            st_next.ref_cfg[k].delay_ps = 11'(coarse * sysref_cfg_pkg::COARSE_STEP_PS)
                                        + 11'(sysref_cfg_pkg::FINE_PS[fine]);
            st_next.ref_cfg[k].src_sysref = dly[sysref_cfg_pkg::SRC_BIT];
            st_next.ref_cfg[k].pd         = rst[sysref_cfg_pkg::PD_BIT];
            st_next.ref_cfg[k].bias       = rst[sysref_cfg_pkg::BIAS_BIT];
            if (rst[sysref_cfg_pkg::PD_BIT]) begin
                st_next.ref_cfg[k].lvpecl = 1'b0;
                st_next.ref_cfg[k].on     = 1'b0;
                st_next.ref_cfg[k].amp_mv = '0;
            end else begin
                st_next.ref_cfg[k].lvpecl = rst[sysref_cfg_pkg::FMT_BIT];
                st_next.ref_cfg[k].on     = st_reg.ref_en[REF_LANES-1-k];
                st_next.ref_cfg[k].amp_mv = 10'((amp + 1) * sysref_cfg_pkg::AMP_STEP_MV);
            end
        end

        // clock output decode
        for (int i = 0; i < CLK_OUTS; i++) begin
            cst = st_reg.clk_st[i];
            amp = cst[sysref_cfg_pkg::AMP_LSB +: 2];
            st_next.clk_cfg[i].pd = cst[sysref_cfg_pkg::PD_BIT];
            if (cst[sysref_cfg_pkg::PD_BIT]) begin
                st_next.clk_cfg[i].lvpecl = 1'b0;
                st_next.clk_cfg[i].on     = 1'b0;
                st_next.clk_cfg[i].amp_mv = '0;
            end else begin
                st_next.clk_cfg[i].lvpecl = cst[sysref_cfg_pkg::FMT_BIT];
                st_next.clk_cfg[i].on     = clk_en_all[sysref_cfg_pkg::CLK_EN_POS[i]];
                st_next.clk_cfg[i].amp_mv = 10'((amp + 1) * sysref_cfg_pkg::AMP_STEP_MV);
            end
        end
    end

    // register bank
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_reg         <= '0;
            st_reg.ref_dly <= {sysref_cfg_pkg::REF_REGS{sysref_cfg_pkg::REF_DLY_RST}};
            st_reg.ref_st  <= {sysref_cfg_pkg::REF_REGS{sysref_cfg_pkg::REF_ST_RST}};
            st_reg.clk_st  <= {CLK_OUTS{sysref_cfg_pkg::CLK_ST_RST}};
            st_reg.clk_en0 <= sysref_cfg_pkg::EN_RST;
            st_reg.clk_en1 <= sysref_cfg_pkg::EN_RST;
            st_reg.ref_en  <= sysref_cfg_pkg::EN_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // source choice per reference lane, gating enables per reference lane and clock output
    always_comb begin
        for (int k = 0; k < REF_LANES; k++) begin
            // channel clock when select is 0
            // central sysref when select is 1
            ref_src_pin[k] = st_reg.ref_cfg[k].src_sysref ? sysref_in : chan_div_clk[k];
            ref_on[k]      = st_reg.ref_cfg[k].on;
        end
        for (int i = 0; i < CLK_OUTS; i++) begin
            clk_on[i] = st_reg.clk_cfg[i].on;
        end
    end

    for (genvar k = 0; k < REF_LANES; k++) begin : g_ref
        out_lane_gate #(
            .SYNC_STAGES (2)
        ) u_gate (
            .core_clk  (core_clk),
            .rstn      (rstn),
            .src_in    (ref_src_pin[k]),
            .on        (ref_on[k]),
            .gated_out (reference_output[k])
        );
    end

    for (genvar i = 0; i < CLK_OUTS; i++) begin : g_clk
        out_lane_gate #(
            .SYNC_STAGES (2)
        ) u_gate (
            .core_clk  (core_clk),
            .rstn      (rstn),
            .src_in    (clk_src[i]),
            .on        (clk_on[i]),
            .gated_out (clock_output[i])
        );
    end

    assign reg_rdata  = st_reg.rdata;
    assign reg_rvalid = st_reg.rvalid;
    assign ref_cfg    = st_reg.ref_cfg;
    assign clk_cfg    = st_reg.clk_cfg;

endmodule // sysref_output_config_regs

// ==== tb/sysref_output_config_regs_asserts.sv ====
`timescale 1ns/10ps
module sysref_output_config_regs_asserts #(
    parameter int REF_LANES = 8,
    parameter int CLK_OUTS  = 8
) (
    input wire logic                               core_clk,
    input wire logic                               rstn,
    input wire logic [7:0]                         reg_addr,
    input wire logic [7:0]                         reg_wdata,
    input wire logic                               reg_wr,
    input wire logic                               reg_rd,
    input wire logic [7:0]                         reg_rdata,
    input wire logic                               reg_rvalid,
    input wire logic                               sysref_in,
    input wire logic [REF_LANES-1:0]               chan_div_clk,
    input wire logic [CLK_OUTS-1:0]                clk_src,
    input wire logic [REF_LANES-1:0]               reference_output,
    input wire logic [CLK_OUTS-1:0]                clock_output,
    input wire sysref_cfg_pkg::ref_out_cfg_s [7:0] ref_cfg,
    input wire sysref_cfg_pkg::clk_out_cfg_s [7:0] clk_cfg
);
    logic [7:0] ref_on;

    // expected delay and amplitude of a written byte
    function automatic int dly(logic [7:0] d);
        int ft [8] = '{0, 25, 50, 75, 85, 110, 135, 160};
        return int'(d[3:1]) * 255 + ft[{d[0], d[6:5]}];
    endfunction
    function automatic int amp(logic [7:0] d);
        return d[7] ? 0 : int'(d[3:2]) * 250 + 250;
    endfunction

    // gather lane enables
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            ref_on[i] = ref_cfg[i].on;
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);

    a_read_answer: assert property (reg_rd |=> reg_rvalid)
        else $error("read strobe not answered");
    a_rvalid_lone: assert property (!reg_rd |=> !reg_rvalid)
        else $error("answer without read");
    a_unmapped_zero: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_delay_decode: assert property (reg_wr && reg_addr == 8'h28 ##1 !(reg_wr && reg_addr == 8'h28)
        |=> int'(ref_cfg[0].delay_ps) == dly($past(reg_wdata, 2))) else $error("delay decode wrong");
    a_src_decode: assert property (reg_wr && reg_addr == 8'h28 ##1 !(reg_wr && reg_addr == 8'h28)
        |=> (ref_cfg[0].src_sysref ? 8'h10 : 8'h00) == ($past(reg_wdata, 2) & 8'h10)) else $error("source wrong");
    a_amp_decode: assert property (reg_wr && reg_addr == 8'h2c ##1 !(reg_wr && reg_addr == 8'h2c)
        |=> int'(ref_cfg[0].amp_mv) == amp($past(reg_wdata, 2))) else $error("amplitude decode wrong");
    a_pd_override: assert property (ref_cfg[0].pd |-> !ref_cfg[0].on && !ref_cfg[0].lvpecl
        && ref_cfg[0].amp_mv == 10'h000) else $error("power-down not overriding");
    a_off_low: assert property (1'b1 |=> (reference_output & ~$past(ref_on)) == 8'h00)
        else $error("disabled output not low");
    a_en_decode: assert property (reg_wr && reg_addr == 8'h76 ##1 !(reg_wr && reg_addr == 8'h76)
        |=> ref_cfg[0].on == ($past(reg_wdata, 2) >= 8'h80 && !ref_cfg[0].pd)) else $error("enable bit wrong");
endmodule // sysref_output_config_regs_asserts

bind sysref_output_config_regs sysref_output_config_regs_asserts #(.REF_LANES(REF_LANES), .CLK_OUTS(CLK_OUTS))
    sysref_output_config_regs_asserts_inst (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .sysref_in(sysref_in), .chan_div_clk(chan_div_clk), .clk_src(clk_src), .reference_output(reference_output),
    .clock_output(clock_output), .ref_cfg(ref_cfg), .clk_cfg(clk_cfg));

// ==== tb/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
    logic                               core_clk = 1'b0;
    logic                               rstn = 1'b0;
    logic [7:0]                         reg_addr = 8'h00;
    logic [7:0]                         reg_wdata = 8'h00;
    logic                               reg_wr = 1'b0;
    logic                               reg_rd = 1'b0;
    logic [7:0]                         reg_rdata;
    logic                               reg_rvalid;
    logic                               sysref_in = 1'b0;
    logic [7:0]                         chan_div_clk = 8'h00;
    logic [7:0]                         clk_src = 8'h00;
    logic [7:0]                         reference_output;
    logic [7:0]                         clock_output;
    sysref_cfg_pkg::ref_out_cfg_s [7:0] ref_cfg;
    sysref_cfg_pkg::clk_out_cfg_s [7:0] clk_cfg;
    int                                 error_cnt = 0;
    int                                 comparisons = 0;
    logic                               rand_src = 1'b1;
    logic [7:0]                         d;
    int                                 lane_of [7] = '{0, 1, 2, 3, 4, 5, 7};

    sysref_output_config_regs sysref_output_config_regs_inst (.core_clk(core_clk), .rstn(rstn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .sysref_in(sysref_in), .chan_div_clk(chan_div_clk), .clk_src(clk_src),
        .reference_output(reference_output), .clock_output(clock_output), .ref_cfg(ref_cfg), .clk_cfg(clk_cfg));

    always #25 core_clk = ~core_clk;

    // random source levels while registers are exercised
    always @(posedge core_clk) begin
        if (rand_src) begin
            sysref_in <= 1'($urandom);
            chan_div_clk <= 8'($urandom);
            clk_src <= 8'($urandom);
        end
    end

    function automatic logic [31:0] exp_dly(logic [7:0] v);
        int ft [8] = '{0, 25, 50, 75, 85, 110, 135, 160};
        return 32'(v[3:1]) * 255 + 32'(ft[{v[0], v[6:5]}]);
    endfunction
    function automatic logic [31:0] exp_amp(logic [7:0] v);
        return v[7] ? 32'h0 : 32'(v[3:2]) * 250 + 250;
    endfunction

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(logic [31:0] got, logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t: seen %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic wr(logic [7:0] a, logic [7:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    // read with bounded wait for the answer marker
    task automatic rd(logic [7:0] a, logic [7:0] exp);
        int i;
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        for (i = 0; i < 4; i++) begin
            #1;
            if (reg_rvalid === 1'b1) break;
            @(posedge core_clk);
        end
        if (i == 4) begin
            error_cnt++;
            final_report();
        end else begin
            chk(32'(reg_rdata), 32'(exp));
        end
    endtask

    task automatic settle(int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    initial begin
        void'($urandom(79576));
        repeat (20) @(posedge core_clk);
        rstn <= 1'b1;
        for (int r = 0; r < 7; r++) begin
            rd(sysref_cfg_pkg::REF_DLY_ADDR[r], 8'h10);
            rd(sysref_cfg_pkg::REF_ST_ADDR[r], 8'h00);
        end
        rd(8'h76, 8'h00);
        chk(32'(ref_cfg[0].amp_mv), 32'd250);
        $display("reset values done");
        for (int n = 0; n < 21; n++) begin
            d = (n == 0) ? 8'hff : 8'($urandom);
            wr(sysref_cfg_pkg::REF_DLY_ADDR[n % 7], d);
            rd(sysref_cfg_pkg::REF_DLY_ADDR[n % 7], d & 8'h7f);
            chk(32'(ref_cfg[lane_of[n % 7]].delay_ps), exp_dly(d));
            chk(32'(ref_cfg[lane_of[n % 7]].src_sysref), 32'(d[4]));
            d = (n < 8) ? 8'(8'h43 | (n << 2)) : 8'($urandom);
            wr(sysref_cfg_pkg::REF_ST_ADDR[n % 7], d);
            rd(sysref_cfg_pkg::REF_ST_ADDR[n % 7], d & 8'hbc);
            chk(32'(ref_cfg[lane_of[n % 7]].amp_mv), exp_amp(d));
            chk(32'(ref_cfg[lane_of[n % 7]].lvpecl), 32'(d[4] & ~d[7]));
            chk(32'(ref_cfg[lane_of[n % 7]].bias), 32'(d[5]));
            wr(8'h24, d);
            rd(8'h24, d & 8'h9c);
            chk(32'(clk_cfg[0].amp_mv), exp_amp(d));
        end
        wr(8'h2b, 8'hff);
        rd(8'h2b, 8'h00);
        rd(8'h00, 8'h00);
        $display("field map done");
        // enables and power-down on the outputs
        rand_src <= 1'b0;
        @(posedge core_clk);
        sysref_in <= 1'b1;
        chan_div_clk <= 8'hff;
        clk_src <= 8'hff;
        wr(8'h24, 8'h00);
        for (int r = 0; r < 7; r++) wr(sysref_cfg_pkg::REF_ST_ADDR[r], 8'h00);
        for (int k = 0; k < 8; k++) begin
            wr(8'h76, 8'h80 >> k);
            settle(4);
            chk(32'(reference_output), 32'(8'h01 << k));
        end
        wr(8'h76, 8'hff);
        wr(8'h2c, 8'h80);
        settle(4);
        chk(32'(reference_output), 32'h0fe);
        wr(8'h2c, 8'h00);
        wr(8'h76, 8'h80);
        wr(8'h28, 8'h10);
        @(posedge core_clk);
        chan_div_clk <= 8'h00;
        settle(4);
        chk(32'(reference_output), 32'h001);
        wr(8'h28, 8'h00);
        settle(4);
        chk(32'(reference_output), 32'h000);
        @(posedge core_clk);
        chan_div_clk <= 8'hff;
        settle(4);
        chk(32'(reference_output), 32'h001);
        wr(8'h74, 8'hdb);
        wr(8'h75, 8'h03);
        settle(4);
        chk(32'(clock_output), 32'h0ff);
        wr(8'h74, 8'h00);
        settle(4);
        chk(32'(clock_output), 32'h0c0);
        $display("output gating done");
        final_report();
    end
endmodule // tb_top
